// ### rtl/prmdac_pkg.sv
// Constants for the pulse-ratio multichannel converter core.
// Assumes a single 50 MHz ref_clk; all pin inputs are asynchronous to it.

package prmdac_pkg;

   // ***************************************************
   // Widths
   // ***************************************************
   localparam int CHAN_NUM  = 8;
   localparam int VAL_W     = 6;
   localparam int CHAN_W    = 3;
   localparam int LOAD_W    = 9;
   localparam int GROUP_W   = 3;
   localparam int PIN_NUM   = 8;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLK_PERIOD_NS      = 20;
   localparam int DCLK_MIN_PHASE_NS  = 4000;
   localparam int DCLK_MIN_PHASE_CYC = (DCLK_MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_MIN_NS      = 4000;
   localparam int STROBE_MIN_CYC     = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WIDTH_CNT_W        = 8;
   localparam logic [WIDTH_CNT_W-1:0] WIDTH_CNT_MAX = 8'hff;

   // Counter and interval encoding
   localparam logic [VAL_W-1:0]  CNT_RST  = 6'h00;
   localparam logic [VAL_W-1:0]  CNT_LAST = 6'h3f;
   localparam logic [2:0]        SEL_UNIT = 3'h6;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] REG_IDCODE    = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h08;
   localparam logic [ADDR_W-1:0] REG_LOADWORD  = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_CHAN_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] REG_CHAN_LAST = 8'h2c;

   localparam int CTRL_PARALLEL_BIT  = 0;
   localparam int CTRL_CLRFLAG_BIT   = 1;
   localparam int STAT_CNT_LSB       = 0;
   localparam int STAT_LATCH_BIT     = 6;
   localparam int STAT_ARMED_BIT     = 7;
   localparam int STAT_DCLKSHORT_BIT = 8;
   localparam int STAT_STBSHORT_BIT  = 9;

   localparam logic              CTRL_PARALLEL_RST = 1'b0;
   localparam logic [CHAN_W-1:0] IDCODE_RST        = 3'h5;
   localparam logic [VAL_W-1:0]  RAM_RST           = 6'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : prmdac_pkg

// ### rtl/prmdac_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the caller reads only dataOut, never the first stage.
`timescale 1ns/100ps

module prmdac_sync
   import prmdac_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,   // Core clock
   input  wire logic             reset,     // Async reset, active high
   input  wire logic [WIDTH-1:0] dataIn,    // Asynchronous inputs
   output logic      [WIDTH-1:0] dataOut    // Synchronised inputs
);

   logic [WIDTH-1:0] stage1_ff;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stage1_ff <= '0;
         dataOut   <= '0;
      end else begin
         stage1_ff <= dataIn;
         dataOut   <= stage1_ff;
      end
   end

endmodule : prmdac_sync

// ### rtl/prmdac_top.sv
// Core of the pulse-ratio multichannel converter with AXI4-Lite control.
// Assumes pins are asynchronous to ref_clk and slow against 50 MHz.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module prmdac_top
   import prmdac_pkg::*;
(
   input  wire logic              ref_clk,          // 50 MHz core clock
   input  wire logic              reset,            // Async reset, active high
   input  wire logic              oscIn,            // Timebase pin
   input  wire logic              dataClk,          // Load clock pin
   input  wire logic              serialData,       // Serial load data pin
   input  wire logic              writeStrobe,      // Write strobe pin
   input  wire logic              identify_strobe,  // ID strobe pin
   input  wire logic              group_line_0,     // Parallel group line 0
   input  wire logic              group_line_1,     // Parallel group line 1
   input  wire logic              group_line_2,     // Parallel group line 2
   output logic [CHAN_NUM-1:0]    chanOut,          // Channel pulse streams
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // Write address
   input  wire logic              s_axi_awvalid,    // Write address valid
   output logic                   s_axi_awready,    // Write address ready
   input  wire logic [DATA_W-1:0] s_axi_wdata,      // Write data
   input  wire logic [3:0]        s_axi_wstrb,      // Write byte strobes
   input  wire logic              s_axi_wvalid,     // Write data valid
   output logic                   s_axi_wready,     // Write data ready
   output logic [1:0]             s_axi_bresp,      // Write response
   output logic                   s_axi_bvalid,     // Write response valid
   input  wire logic              s_axi_bready,     // Write response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,     // Read address
   input  wire logic              s_axi_arvalid,    // Read address valid
   output logic                   s_axi_arready,    // Read address ready
   output logic [DATA_W-1:0]      s_axi_rdata,      // Read data
   output logic [1:0]             s_axi_rresp,      // Read response
   output logic                   s_axi_rvalid,     // Read data valid
   input  wire logic              s_axi_rready      // Read data ready
);

   // ***************************************************
   // Functions
   // ***************************************************
   // Priority encoder: first zero bit from the top picks the interval
   function automatic logic [2:0] intervalSel(input logic [VAL_W-1:0] cnt);
      logic [2:0] sel;
      sel = SEL_UNIT;
      for (int i = 0; i < VAL_W; i++) begin
         if (!cnt[i]) begin
            sel = 3'(i);
         end
      end
      return sel;
   endfunction : intervalSel

   function automatic logic isChanAddr(input logic [ADDR_W-1:0] addr);
      return (addr >= REG_CHAN_BASE) && (addr <= REG_CHAN_LAST) && (addr[1:0] == 2'h0);
   endfunction : isChanAddr

   function automatic logic [CHAN_W-1:0] chanIndex(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] off;
      off = addr - REG_CHAN_BASE;
      return off[CHAN_W+1:2];
   endfunction : chanIndex

   // ***************************************************
   // Pin synchronisers and edge detection
   // ***************************************************
   logic [PIN_NUM-1:0] pinSync;
   logic [PIN_NUM-1:0] pinPrev_ff;

   prmdac_sync #(.WIDTH(PIN_NUM)) u_pin_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .dataIn  ({group_line_2, group_line_1, group_line_0, identify_strobe,
                 writeStrobe, serialData, dataClk, oscIn}),
      .dataOut (pinSync)
   );

   logic             oscS;
   logic             dclkS;
   logic             sdataS;
   logic             strobeS;
   logic             idStrobeS;
   logic [GROUP_W-1:0] groupS;
   assign oscS      = pinSync[0];
   assign dclkS     = pinSync[1];
   assign sdataS    = pinSync[2];
   assign strobeS   = pinSync[3];
   assign idStrobeS = pinSync[4];
   assign groupS    = pinSync[7:5];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pinPrev_ff <= '0;
      end else begin
         pinPrev_ff <= pinSync;
      end
   end

   logic oscRise;
   logic dclkFall;
   logic dclkEdge;
   logic strobeRise;
   logic strobeFall;
   logic idRise;
   assign oscRise    = oscS & ~pinPrev_ff[0];
   assign dclkFall   = ~dclkS & pinPrev_ff[1];
   assign dclkEdge   = dclkS ^ pinPrev_ff[1];
   assign strobeRise = strobeS & ~pinPrev_ff[3];
   assign strobeFall = ~strobeS & pinPrev_ff[3];
   assign idRise     = idStrobeS & ~pinPrev_ff[4];

   // ***************************************************
   // Control registers
   // ***************************************************
   logic              parallel_ff;
   logic [CHAN_W-1:0] idCode_ff;
   logic              regWrite;
   logic [ADDR_W-1:0] awAddr_ff;
   logic [DATA_W-1:0] wData_ff;
   logic [3:0]        wStrb_ff;
   logic              clrFlags;

   assign clrFlags = regWrite && (awAddr_ff == REG_CTRL) && wStrb_ff[0] && wData_ff[CTRL_CLRFLAG_BIT];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         parallel_ff <= CTRL_PARALLEL_RST;
         idCode_ff   <= IDCODE_RST;
      end else if (regWrite && wStrb_ff[0]) begin
         if (awAddr_ff == REG_CTRL) begin
            parallel_ff <= wData_ff[CTRL_PARALLEL_BIT];
         end else if (awAddr_ff == REG_IDCODE) begin
            idCode_ff <= wData_ff[CHAN_W-1:0];
         end
      end
   end

   // ***************************************************
   // Timebase and conversion counter
   // ***************************************************
   logic             tbHalf_ff;
   logic [VAL_W-1:0] cnt_ff;
   logic             cntTick;
   logic             cycleStart;

   assign cntTick    = oscRise & tbHalf_ff;
   assign cycleStart = cntTick && (cnt_ff == CNT_LAST);

   // Free running; nothing from the load path touches it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tbHalf_ff <= 1'b0;
         cnt_ff    <= CNT_RST;
      end else if (oscRise) begin
         tbHalf_ff <= ~tbHalf_ff;
         if (tbHalf_ff) begin
            cnt_ff <= cnt_ff + 6'h01;
         end
      end
   end

   // ***************************************************
   // Load path
   // ***************************************************
   logic [LOAD_W-1:0] loadWord_ff;
   logic              idArmed_ff;
   logic              latch_ff;
   logic              ramWrite;
   logic [CHAN_W-1:0] loadChan;
   logic [VAL_W-1:0]  loadVal;

   assign loadChan = loadWord_ff[LOAD_W-1:VAL_W];
   assign loadVal  = loadWord_ff[VAL_W-1:0];
   assign ramWrite = latch_ff & cycleStart;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         loadWord_ff <= '0;
      end else if (dclkFall) begin
         if (!parallel_ff) begin
            loadWord_ff <= {loadWord_ff[LOAD_W-2:0], sdataS};
         end else if (idArmed_ff) begin
            loadWord_ff <= {loadWord_ff[LOAD_W-GROUP_W-1:0], groupS};
         end
      end
   end

   // ID accepted on a matching strobe, dropped after the transfer
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         idArmed_ff <= 1'b0;
      end else if (idRise) begin
         idArmed_ff <= (groupS == idCode_ff);
      end else if (ramWrite) begin
         idArmed_ff <= 1'b0;
      end
   end

   // New strobe edge wins over the clear
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         latch_ff <= 1'b0;
      end else if (strobeRise) begin
         latch_ff <= 1'b1;
      end else if (ramWrite) begin
         latch_ff <= 1'b0;
      end
   end

   // ***************************************************
   // Pin timing monitors
   // ***************************************************
   logic [WIDTH_CNT_W-1:0] dclkWidth_ff;
   logic [WIDTH_CNT_W-1:0] stbWidth_ff;
   logic                   dclkShort_ff;
   logic                   stbShort_ff;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dclkWidth_ff <= '0;
         stbWidth_ff  <= '0;
      end else begin
         dclkWidth_ff <= dclkEdge ? '0 : (dclkWidth_ff == WIDTH_CNT_MAX ? dclkWidth_ff : dclkWidth_ff + 8'h01);
         stbWidth_ff  <= strobeRise ? '0 : (stbWidth_ff == WIDTH_CNT_MAX ? stbWidth_ff : stbWidth_ff + 8'h01);
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dclkShort_ff <= 1'b0;
         stbShort_ff  <= 1'b0;
      end else begin
         if (dclkEdge && (dclkWidth_ff < WIDTH_CNT_W'(DCLK_MIN_PHASE_CYC - 1))) begin
            dclkShort_ff <= 1'b1;
         end else if (clrFlags) begin
            dclkShort_ff <= 1'b0;
         end
         if (strobeFall && (stbWidth_ff < WIDTH_CNT_W'(STROBE_MIN_CYC - 1))) begin
            stbShort_ff <= 1'b1;
         end else if (clrFlags) begin
            stbShort_ff <= 1'b0;
         end
      end
   end

   // ***************************************************
   // Control-word RAM and channel outputs
   // ***************************************************
   logic [VAL_W-1:0] ram_ff [CHAN_NUM];
   logic [2:0]       sel;
   logic             writeOk;

   assign sel     = intervalSel(cnt_ff);
   assign writeOk = !(parallel_ff && (loadChan == CHAN_W'(CHAN_NUM - 1)));

   generate
      for (genvar ch = 0; ch < CHAN_NUM; ch++) begin : g_chan
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               ram_ff[ch] <= RAM_RST;
            end else if (ramWrite && writeOk && (loadChan == CHAN_W'(ch))) begin
               ram_ff[ch] <= loadVal;
            end
         end

         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               chanOut[ch] <= 1'b0;
            end else if (sel == SEL_UNIT) begin
               chanOut[ch] <= 1'b0;
            end else if (parallel_ff && (ch == CHAN_NUM - 1)) begin
               chanOut[ch] <= 1'b0;
            end else begin
               chanOut[ch] <= ram_ff[ch][sel];
            end
         end
      end
   endgenerate

   // ***************************************************
   // AXI4-Lite write channel
   // ***************************************************
   logic awGot_ff;
   logic wGot_ff;

   assign regWrite = awGot_ff & wGot_ff & ~s_axi_bvalid;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         awGot_ff      <= 1'b0;
         wGot_ff       <= 1'b0;
         awAddr_ff     <= '0;
         wData_ff      <= '0;
         wStrb_ff      <= '0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awGot_ff      <= 1'b1;
            awAddr_ff     <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wGot_ff      <= 1'b1;
            wData_ff     <= s_axi_wdata;
            wStrb_ff     <= s_axi_wstrb;
         end
         if (regWrite) begin
            awGot_ff     <= 1'b0;
            wGot_ff      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_ff == REG_CTRL || awAddr_ff == REG_IDCODE) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ***************************************************
   // AXI4-Lite read channel
   // ***************************************************
   logic [DATA_W-1:0] rdData;
   logic [1:0]        rdResp;

   always_comb begin
      rdData = '0;
      rdResp = RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
         rdData[CTRL_PARALLEL_BIT] = parallel_ff;
      end else if (s_axi_araddr == REG_IDCODE) begin
         rdData[CHAN_W-1:0] = idCode_ff;
      end else if (s_axi_araddr == REG_STATUS) begin
         rdData[STAT_CNT_LSB +: VAL_W] = cnt_ff;
         rdData[STAT_LATCH_BIT]        = latch_ff;
         rdData[STAT_ARMED_BIT]        = idArmed_ff;
         rdData[STAT_DCLKSHORT_BIT]    = dclkShort_ff;
         rdData[STAT_STBSHORT_BIT]     = stbShort_ff;
      end else if (s_axi_araddr == REG_LOADWORD) begin
         rdData[LOAD_W-1:0] = loadWord_ff;
      end else if (isChanAddr(s_axi_araddr)) begin
         rdData[VAL_W-1:0] = ram_ff[chanIndex(s_axi_araddr)];
      end else begin
         rdResp = RESP_SLVERR;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdData;
         s_axi_rresp   <= rdResp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : prmdac_top

// ### dv/prmdac_props.sv
// Checker of bus answers and channel output pacing at the core ports.
// Assumes a timebase no faster than 2 MHz against ref_clk.
`timescale 1ns/100ps

module prmdac_props
   import prmdac_pkg::*;
(
   input wire logic                ref_clk,       // Core clock
   input wire logic                reset,         // Async reset
   input wire logic [CHAN_NUM-1:0] chanOut,       // Channel streams
   input wire logic                s_axi_awvalid, // AW valid
   input wire logic                s_axi_awready, // AW ready
   input wire logic                s_axi_wvalid,  // W valid
   input wire logic                s_axi_wready,  // W ready
   input wire logic [1:0]          s_axi_bresp,   // B response
   input wire logic                s_axi_bvalid,  // B valid
   input wire logic                s_axi_bready,  // B ready
   input wire logic [ADDR_W-1:0]   s_axi_araddr,  // AR address
   input wire logic                s_axi_arvalid, // AR valid
   input wire logic                s_axi_arready, // AR ready
   input wire logic [DATA_W-1:0]   s_axi_rdata,   // R data
   input wire logic [1:0]          s_axi_rresp,   // R response
   input wire logic                s_axi_rvalid,  // R valid
   input wire logic                s_axi_rready   // R ready
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // ***************************************************
   // Handshake steps
   // ***************************************************
   sequence wrBoth;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_answer: assert property (wrBoth |-> ##2 s_axi_bvalid) else $error("write response missing");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
   a_read_answer: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read not closed");
   a_unmapped_read: assert property (rdTaken ##0 (s_axi_araddr > REG_CHAN_LAST || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   a_reset_quiet: assert property ($fell(reset) |-> chanOut == 8'h00) else $error("outputs active after reset");
   a_output_pace: assert property ($changed(chanOut[6:0]) |=> $stable(chanOut[6:0]) [*8])
      else $error("output changed too soon");
endmodule : prmdac_props

// ### dv/prmdac_host.sv
// Host port model: serial or grouped loads, ID handshake and write strobe.
// Assumes each task call starts just after a ref_clk rising edge.
`timescale 1ns/100ps

module prmdac_host
   import prmdac_pkg::*;
(
   input  wire logic ref_clk,         // Core clock, paces the pins
   output logic      dataClk,         // Load clock
   output logic      serialData,      // Serial data
   output logic      writeStrobe,     // Write strobe
   output logic      identify_strobe, // ID strobe
   output logic      group_line_0,    // Group bit 0
   output logic      group_line_1,    // Group bit 1
   output logic      group_line_2     // Group bit 2
);
   initial begin
      dataClk = 1'b0;
      serialData = 1'b0;
      writeStrobe = 1'b0;
      identify_strobe = 1'b0;
      {group_line_2, group_line_1, group_line_0} = 3'h0;
   end

   task automatic load(input logic par, input logic [2:0] id, input logic [LOAD_W-1:0] word, input logic stb);
      if (par) begin
         {group_line_2, group_line_1, group_line_0} <= id;
         repeat (4) @(posedge ref_clk);
         identify_strobe <= 1'b1;
         repeat (4) @(posedge ref_clk);
         identify_strobe <= 1'b0;
      end
      for (int i = 0; i < (par ? 3 : LOAD_W); i++) begin
         dataClk <= 1'b1;
         if (par) {group_line_2, group_line_1, group_line_0} <= word[LOAD_W-1-3*i -: 3];
         else serialData <= word[LOAD_W-1-i];
         repeat (4) @(posedge ref_clk);
         dataClk <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
      // Released lines show no stale value
      serialData <= ~serialData;
      {group_line_2, group_line_1, group_line_0} <= ~{group_line_2, group_line_1, group_line_0};
      if (stb) begin
         repeat (50) @(posedge ref_clk);
         writeStrobe <= 1'b1;
         repeat (250) @(posedge ref_clk);
         writeStrobe <= 1'b0;
      end
      @(posedge ref_clk);
   endtask : load
endmodule : prmdac_host

// ### dv/prmdac_tb_top.sv
// Self-checking bench: bus reads and writes, serial and grouped loads, duty.
// Assumes the host model drives the load pins and the checker is bound.
`timescale 1ns/100ps

module prmdac_tb_top;
   import prmdac_pkg::*;
   localparam int TICK_CYC = 52;
   localparam int CONV_CYC = 64 * TICK_CYC;
   logic ref_clk = 1'b0, reset = 1'b1, oscIn = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [DATA_W-1:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DATA_W-1:0] s_axi_rdata;
   logic [CHAN_NUM-1:0] chanOut;
   logic dataClk, serialData, writeStrobe, identify_strobe, group_line_0, group_line_1, group_line_2;
   logic [33:0] expQ[$];
   logic [5:0] vals[CHAN_NUM];
   logic [16:0] seed = 17'h17a3c;
   int oscDiv = 0, fails = 0, comparisons = 0;

   prmdac_top i_prmdac_top (.ref_clk(ref_clk), .reset(reset), .oscIn(oscIn), .dataClk(dataClk),
      .serialData(serialData), .writeStrobe(writeStrobe), .identify_strobe(identify_strobe),
      .group_line_0(group_line_0), .group_line_1(group_line_1), .group_line_2(group_line_2), .chanOut(chanOut),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   prmdac_host i_prmdac_host (.ref_clk(ref_clk), .dataClk(dataClk), .serialData(serialData),
      .writeStrobe(writeStrobe), .identify_strobe(identify_strobe), .group_line_0(group_line_0),
      .group_line_1(group_line_1), .group_line_2(group_line_2));

   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      oscDiv <= (oscDiv == 12) ? 0 : oscDiv + 1;
      if (oscDiv == 12) oscIn <= ~oscIn;
   end

   function automatic logic [16:0] lfsrNext(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsrNext

   task automatic cmpWord(input logic [33:0] e, input logic [33:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("unexpected word at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmpWord

   task automatic cmpCount(input int e, input int g);
      comparisons++;
      if (g != e) begin
         fails++;
         $display("unexpected count at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmpCount

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // ***************************************************
   // Bus master
   // ***************************************************
   task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r);
      expQ.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
   endtask : axiWrite

   task automatic axiRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r);
      expQ.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge ref_clk);
   endtask : axiRead

   always @(posedge ref_clk) begin
      if (s_axi_bvalid && s_axi_bready) cmpWord(expQ.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) cmpWord(expQ.pop_front(), {s_axi_rresp, s_axi_rdata});
   end

   // High time over one cycle equals value ticks; zero for channel 7 in parallel mode
   task automatic measureAll(input logic par);
      int cnt[CHAN_NUM];
      for (int i = 0; i < CHAN_NUM; i++) cnt[i] = 0;
      repeat (CONV_CYC) begin
         @(posedge ref_clk);
         for (int i = 0; i < CHAN_NUM; i++) cnt[i] += int'(chanOut[i] === 1'b1);
      end
      for (int i = 0; i < CHAN_NUM; i++) cmpCount((par && i == 7) ? 0 : int'(vals[i]) * TICK_CYC, cnt[i]);
   endtask : measureAll

   initial begin : mainSeq
      logic [2:0] idc;
      logic [5:0] v;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      axiRead(REG_CTRL, 32'h0, RESP_OKAY);
      axiRead(REG_IDCODE, {29'h0, IDCODE_RST}, RESP_OKAY);
      axiRead(8'h40, 32'h0, RESP_SLVERR);
      axiWrite(8'h30, 32'h1, RESP_SLVERR);
      seed = lfsrNext(seed);
      idc = seed[2:0];
      axiWrite(REG_IDCODE, {29'h0, idc}, RESP_OKAY);
      s_axi_wstrb <= 4'h0;
      axiWrite(REG_IDCODE, ~s_axi_wdata, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axiRead(REG_IDCODE, {29'h0, idc}, RESP_OKAY);
      $display("test registers done");
      for (int ch = 0; ch < CHAN_NUM; ch++) begin
         seed = lfsrNext(seed);
         vals[ch] = seed[5:0];
         i_prmdac_host.load(1'b0, 3'h0, {ch[2:0], vals[ch]}, 1'b1);
         repeat (CONV_CYC + 100) @(posedge ref_clk);
         axiRead(REG_CHAN_BASE + 8'(4 * ch), {26'h0, vals[ch]}, RESP_OKAY);
      end
      fork
         measureAll(1'b0);
         i_prmdac_host.load(1'b0, 3'h0, 9'h07f, 1'b0);
      join
      axiRead(REG_LOADWORD, 32'h7f, RESP_OKAY);
      $display("test serial done");
      axiWrite(REG_CTRL, 32'h1, RESP_OKAY);
      i_prmdac_host.load(1'b1, idc ^ 3'h1, {3'h2, ~vals[2]}, 1'b0);
      axiRead(REG_LOADWORD, 32'h7f, RESP_OKAY);
      v = ~vals[2];
      i_prmdac_host.load(1'b1, idc, {3'h2, v}, 1'b1);
      vals[2] = v;
      repeat (CONV_CYC + 100) @(posedge ref_clk);
      axiRead(REG_CHAN_BASE + 8'h08, {26'h0, v}, RESP_OKAY);
      i_prmdac_host.load(1'b1, idc, {3'h7, ~vals[7]}, 1'b1);
      repeat (CONV_CYC + 100) @(posedge ref_clk);
      axiRead(REG_CHAN_LAST, {26'h0, vals[7]}, RESP_OKAY);
      measureAll(1'b1);
      $display("test parallel done");
      finish_test();
   end

   initial begin : watchdog
      repeat (90000) @(posedge ref_clk);
      fails++;
      finish_test();
   end
endmodule : prmdac_tb_top

bind prmdac_top prmdac_props i_prmdac_props (.ref_clk(ref_clk), .reset(reset), .chanOut(chanOut),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
